// *** rtl/rffc_flow_ctl.sv ***
// receive fifo flow controller: pause frames in full duplex any-frame mode, jam in half duplex
// assumes all inputs are synchronous to core_clk and the mac holds frame flags as pulses
`timescale 1ns/1ps
`default_nettype none

module rffc_flow_ctl
    import rffc_pkg::*;
#(
    parameter int FILL_W       = FILL_W_DEF,
    parameter int JAM_UNIT_CYC = JAM_UNIT_CYC_DEF
) (
    input  wire logic                         core_clk,
    input  wire logic                         rst_n,
    input  wire logic                         full_duplex,
    input  wire logic                         link_10m,
    input  wire logic [FILL_W-1:0]            rx_fill_bytes,
    input  wire logic [rffc_pkg::MARK_W-1:0]  rx_fill_high_mark,
    input  wire logic [rffc_pkg::MARK_W-1:0]  rx_fill_low_mark,
    input  wire logic [rffc_pkg::DUR_W-1:0]   jam_duration_sel,
    input  wire logic                         flow_ctl_any_frame,
    input  wire logic                         flow_ctl_on_multicast,
    input  wire logic                         flow_ctl_on_broadcast,
    input  wire logic                         flow_ctl_on_own_address,
    input  wire logic [rffc_pkg::PAUSE_W-1:0] pause_time_value,
    input  wire logic                         rx_preamble_ok,
    input  wire logic                         rx_dest_valid,
    input  wire logic                         rx_is_multicast,
    input  wire logic                         rx_is_broadcast,
    input  wire logic                         rx_addr_match,
    input  wire logic                         pause_ack,
    output logic                              pause_req,
    output logic [rffc_pkg::PAUSE_W-1:0]      pause_time,
    output logic                              jam_active,
    output logic                              pause_outstanding
);
    import rffc_pkg::*;

    if (FILL_W < MARK_W + FILL_UNIT_SHIFT) begin : g_bad_fill
        $error("FILL_W too narrow for the mark fields");
    end

    // ==========================================================
    // reset release
    logic [1:0] rst_pipe_q;
    logic       rst_sync_n;

    // the raw reset only clears; release passes two flops
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_pipe_q <= 2'h0;
        end else begin
            rst_pipe_q <= {rst_pipe_q[0], 1'b1};
        end
    end

    assign rst_sync_n = rst_pipe_q[1];

    // ==========================================================
    // fill level compare
    function automatic logic [FILL_W-1:0] mark_to_bytes(input logic [MARK_W-1:0] m);
        return FILL_W'({m, {FILL_UNIT_SHIFT{1'b0}}});
    endfunction : mark_to_bytes

    logic hi_reached;
    logic lo_below;
    logic fd_en;
    logic frame_hit;

    assign hi_reached = (rx_fill_bytes >= mark_to_bytes(rx_fill_high_mark));
    assign lo_below   = (rx_fill_bytes <  mark_to_bytes(rx_fill_low_mark));

    // full duplex flow control exists only in any-frame mode
    assign fd_en = full_duplex && flow_ctl_any_frame;

    assign frame_hit = flow_ctl_any_frame ? rx_preamble_ok :
                       (rx_dest_valid &&
                        ((flow_ctl_on_multicast   && rx_is_multicast) ||
                         (flow_ctl_on_broadcast   && rx_is_broadcast) ||
                         (flow_ctl_on_own_address && rx_addr_match)));

    // ==========================================================
    // state
    typedef struct packed {
        rffc_pause_st_t             pst;
        logic [PAUSE_W-1:0]         ptime;
        logic                       jam_start;
    } rffc_ctl_st_t;

    rffc_ctl_st_t st_q;
    rffc_ctl_st_t st_d;

    rffc_jam_if jam_bus ();

    always_comb begin
        st_d           = st_q;
        st_d.jam_start = 1'b0;
        case (st_q.pst)
            PS_OPEN: begin
                // immediate pause request at high mark
                if (fd_en && hi_reached) begin
                    st_d.pst   = PS_REQ_PAUSE;
                    st_d.ptime = pause_time_value;
                end
            end
            PS_REQ_PAUSE: begin
                // request stays up until the mac queues it
                if (pause_ack) begin
                    st_d.pst = PS_PAUSED;
                end
            end
            PS_PAUSED: begin
                if (!fd_en) begin
                    st_d.pst = PS_OPEN;
                end else if (lo_below) begin
                    st_d.pst   = PS_REQ_RESUME;
                    st_d.ptime = '0;
                end
            end
            PS_REQ_RESUME: begin
                if (pause_ack) begin
                    st_d.pst = PS_OPEN;
                end
            end
            default: begin
                st_d.pst = PS_OPEN;
            end
        endcase
        // half duplex backpressure at high mark
        if (!full_duplex && hi_reached && frame_hit && !jam_bus.busy && !st_q.jam_start) begin
            st_d.jam_start = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            st_q <= '{pst: PS_OPEN, ptime: '0, jam_start: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    // ==========================================================
    // jam timer
    assign jam_bus.start     = st_q.jam_start;
    assign jam_bus.speed_10m = link_10m;
    assign jam_bus.dur_sel   = jam_duration_sel;

    rffc_jam_timer #(
        .JAM_UNIT_CYC (JAM_UNIT_CYC)
    ) u_jam_timer (
        .core_clk   (core_clk),
        .rst_sync_n (rst_sync_n),
        .jam        (jam_bus.tmr)
    );

    // ==========================================================
    // outputs
    assign pause_req         = (st_q.pst == PS_REQ_PAUSE) || (st_q.pst == PS_REQ_RESUME);
    assign pause_time        = st_q.ptime;
    assign jam_active        = jam_bus.busy;
    assign pause_outstanding = (st_q.pst == PS_PAUSED) || (st_q.pst == PS_REQ_RESUME);

    // ==========================================================
    // checks
    property p_fd_pause_high;
        @(posedge core_clk) disable iff (!rst_sync_n)
        (st_q.pst == PS_OPEN && fd_en && hi_reached)
            |=> pause_req && pause_time == $past(pause_time_value);
    endproperty
    a_fd_pause_high: assert property (p_fd_pause_high)
        else $error("no pause request at high mark");

    property p_single_pause;
        @(posedge core_clk) disable iff (!rst_sync_n)
        (st_q.pst == PS_PAUSED && !lo_below) |=> !pause_req;
    endproperty
    a_single_pause: assert property (p_single_pause)
        else $error("second pause while still paused");

    property p_resume_zero;
        @(posedge core_clk) disable iff (!rst_sync_n)
        (st_q.pst == PS_PAUSED && fd_en && lo_below) |=> pause_req && pause_time == '0;
    endproperty
    a_resume_zero: assert property (p_resume_zero)
        else $error("low mark did not request zero pause");

    property p_resume_after_pause;
        @(posedge core_clk) disable iff (!rst_sync_n)
        ($rose(pause_req) && pause_time == '0 && $past(pause_outstanding))
            or ($rose(pause_req) && $past(st_q.pst) == PS_OPEN) or !$rose(pause_req);
    endproperty
    a_resume_after_pause: assert property (p_resume_after_pause)
        else $error("pause request from wrong state");

    property p_hd_preamble;
        @(posedge core_clk) disable iff (!rst_sync_n)
        (!full_duplex && flow_ctl_any_frame && hi_reached && rx_preamble_ok
            && !jam_bus.busy && !st_q.jam_start) |-> ##2 jam_active;
    endproperty
    a_hd_preamble: assert property (p_hd_preamble)
        else $error("preamble did not start jam");

    property p_any_override;
        @(posedge core_clk) disable iff (!rst_sync_n)
        (flow_ctl_any_frame && !rx_preamble_ok) |=> !st_q.jam_start;
    endproperty
    a_any_override: assert property (p_any_override)
        else $error("jam without preamble in any-frame mode");

    property p_no_fd_jam;
        @(posedge core_clk) disable iff (!rst_sync_n)
        full_duplex |=> !st_q.jam_start;
    endproperty
    a_no_fd_jam: assert property (p_no_fd_jam)
        else $error("jam started in full duplex");

    property p_no_jam_low;
        @(posedge core_clk) disable iff (!rst_sync_n)
        !hi_reached |=> !st_q.jam_start;
    endproperty
    a_no_jam_low: assert property (p_no_jam_low)
        else $error("jam below high mark");

    property p_level_cmp;
        @(posedge core_clk) disable iff (!rst_sync_n)
        hi_reached == (32'(rx_fill_bytes) >= 32'(rx_fill_high_mark) * 32'h40);
    endproperty
    a_level_cmp: assert property (p_level_cmp)
        else $error("high mark compare wrong");

endmodule : rffc_flow_ctl

`default_nettype wire

// *** rtl/rffc_pkg.sv ***
// constants, types and helpers of the receive fifo flow controller
// assumes a single 100 MHz core clock shared by every module of the block
package rffc_pkg;

    // ==========================================================
    // clock and fill level
    localparam int CLK_PERIOD_NS   = 10;
    localparam int FILL_UNIT_SHIFT = 6;
    localparam int FILL_W_DEF      = 14;
    localparam int MARK_W          = 8;
    localparam int DUR_W           = 4;
    localparam int PAUSE_W         = 16;

    // ==========================================================
    // jam timing, counted in units of 100 ns
    localparam int JAM_UNIT_NS          = 100;
    localparam int JAM_UNIT_CYC_DEF     = (JAM_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int NS_PER_US            = 1000;
    localparam int JAM_US_SHORT [4]     = '{5, 10, 15, 25};
    localparam int JAM_SHORT_CODES      = 3;
    localparam int JAM_STEP_US          = 50;
    localparam int JAM_SLOW_EXTRA_NS    = 2200;
    localparam int JAM_SLOW_EXTRA_UNITS = JAM_SLOW_EXTRA_NS / JAM_UNIT_NS;
    localparam int JAM_CNT_W            = 13;

    typedef logic [JAM_CNT_W-1:0] rffc_jam_cnt_t;

    // ==========================================================
    // pause handshake states
    typedef enum logic [1:0] {
        PS_OPEN,
        PS_REQ_PAUSE,
        PS_PAUSED,
        PS_REQ_RESUME
    } rffc_pause_st_t;

    // ==========================================================
    // jam units from code and speed
    // jam length in 100 ns units for a duration code and link speed
    function automatic rffc_jam_cnt_t rffc_jam_units(
        input logic [DUR_W-1:0] sel,
        input logic             slow
    );
        int us;
        int units;
        if (int'(sel) <= JAM_SHORT_CODES) begin
            us = JAM_US_SHORT[sel[1:0]];
        end else begin
            us = (int'(sel) - JAM_SHORT_CODES) * JAM_STEP_US;
        end
        units = us * NS_PER_US / JAM_UNIT_NS + (slow ? JAM_SLOW_EXTRA_UNITS : 0);
        return rffc_jam_cnt_t'(units);
    endfunction : rffc_jam_units

endpackage : rffc_pkg

// *** rtl/rffc_jam_if.sv ***
// start and busy signals between the flow controller and its jam timer
// assumes both ends run on the same core clock
`timescale 1ns/1ps
`default_nettype none

interface rffc_jam_if;
    import rffc_pkg::*;

    logic                 start;
    logic                 speed_10m;
    logic [DUR_W-1:0]     dur_sel;
    logic                 busy;

    modport ctl (output start, output speed_10m, output dur_sel, input busy);
    modport tmr (input start, input speed_10m, input dur_sel, output busy);
endinterface : rffc_jam_if

`default_nettype wire

// *** rtl/rffc_jam_timer.sv ***
// backpressure jam timer: holds busy for the selected jam time
// assumes start is a one-cycle pulse, ignored while busy
`timescale 1ns/1ps
`default_nettype none

module rffc_jam_timer
    import rffc_pkg::*;
#(
    parameter int JAM_UNIT_CYC = JAM_UNIT_CYC_DEF
) (
    input  wire logic  core_clk,
    input  wire logic  rst_sync_n,
    rffc_jam_if.tmr    jam
);
    import rffc_pkg::*;

    localparam int PRE_W = $clog2(JAM_UNIT_CYC + 1);

    if (JAM_UNIT_CYC < 1) begin : g_bad_unit
        $error("JAM_UNIT_CYC must be at least one");
    end

    typedef struct packed {
        logic               busy;
        rffc_jam_cnt_t      left;
        rffc_jam_cnt_t      term;
        logic [PRE_W-1:0]   pre;
    } rffc_tmr_st_t;

    rffc_tmr_st_t st_q;
    rffc_tmr_st_t st_d;
    logic         tick;

    // ==========================================================
    // divider and down counter
    assign tick = (st_q.pre == PRE_W'(JAM_UNIT_CYC - 1));

    always_comb begin
        st_d = st_q;
        if (!st_q.busy) begin
            if (jam.start) begin
                // terminal count from code and speed
                st_d.busy = 1'b1;
                st_d.term = rffc_jam_units(jam.dur_sel, jam.speed_10m);
                st_d.left = rffc_jam_units(jam.dur_sel, jam.speed_10m);
                st_d.pre  = '0;
            end
        end else begin
            st_d.pre = tick ? '0 : st_q.pre + 1'b1;
            if (tick) begin
                st_d.left = st_q.left - 1'b1;
                if (st_q.left == rffc_jam_cnt_t'(1)) begin
                    st_d.busy = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign jam.busy = st_q.busy;

    // ==========================================================
    // checks
    logic [31:0] elapsed_q;

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            elapsed_q <= 32'h0;
        end else begin
            elapsed_q <= st_q.busy ? elapsed_q + 32'h1 : 32'h0;
        end
    end

    property p_jam_length;
        @(posedge core_clk) disable iff (!rst_sync_n)
        $fell(st_q.busy) |-> elapsed_q == 32'(st_q.term) * 32'(JAM_UNIT_CYC);
    endproperty
    a_jam_length: assert property (p_jam_length)
        else $error("jam period length wrong");

    property p_jam_code;
        @(posedge core_clk) disable iff (!rst_sync_n)
        $rose(st_q.busy) |-> st_q.term == rffc_jam_units($past(jam.dur_sel), $past(jam.speed_10m));
    endproperty
    a_jam_code: assert property (p_jam_code)
        else $error("jam time does not match duration code");

endmodule : rffc_jam_timer

`default_nettype wire

// *** verification/rffc_mac_model.sv ***
// mac transmit side model: takes each pause request after a set delay
// assumes pause_req holds until acknowledged, single core clock
`timescale 1ns/1ps
`default_nettype none

module rffc_mac_model (
    input  wire logic                         core_clk,
    input  wire logic                         rst_n,
    input  wire logic [7:0]                   ack_dly,
    input  wire logic                         pause_req,
    input  wire logic [rffc_pkg::PAUSE_W-1:0] pause_time,
    output logic                              pause_ack,
    output logic [rffc_pkg::PAUSE_W-1:0]      taken_time,
    output logic [7:0]                        taken_cnt
);
    import rffc_pkg::*;

    logic [7:0] wait_q;
    logic       armed_q;

    // ==========================================================
    // transmit window
    // queued for next free window; rearm only after request drops
    // so a request that lingers one cycle is never taken twice
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pause_ack  <= 1'b0;
            taken_time <= '0;
            taken_cnt  <= 8'h00;
            wait_q     <= 8'h00;
            armed_q    <= 1'b1;
        end else begin
            pause_ack <= 1'b0;
            if (!pause_req) begin
                armed_q <= 1'b1;
                wait_q  <= 8'h00;
            end else if (armed_q && wait_q == ack_dly) begin
                pause_ack  <= 1'b1;
                taken_time <= pause_time;
                taken_cnt  <= taken_cnt + 8'h01;
                armed_q    <= 1'b0;
            end else if (armed_q) begin
                wait_q <= wait_q + 8'h01;
            end
        end
    end
endmodule : rffc_mac_model

`default_nettype wire

// *** verification/rffc_flow_ctl_tb.sv ***
// bench for the receive fifo flow controller: pause and jam sequences
// assumes the mac model answers pause requests; jam unit shortened to 1 cycle
`timescale 1ns/1ps
`default_nettype none

`define RFFC_CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
    $display("ERROR %s expected %0h seen %0h", nm, e, g); end end

module rffc_flow_ctl_tb;
    import rffc_pkg::*;

    logic               core_clk = 1'b0;
    logic               rst_n = 1'b0;
    logic               full_duplex = 1'b1;
    logic               link_10m = 1'b0;
    logic [13:0]        rx_fill_bytes = 14'h007F;
    logic [MARK_W-1:0]  hi_mark = 8'h02;
    logic [MARK_W-1:0]  lo_mark = 8'h01;
    logic [DUR_W-1:0]   dur_sel = 4'h0;
    logic               any_f = 1'b1;
    logic [2:0]         sel = 3'h0;
    logic [PAUSE_W-1:0] ptv = 16'hA5C3;
    logic [4:0]         frm = 5'h00;
    logic               pause_ack;
    logic               pause_req;
    logic [PAUSE_W-1:0] pause_time;
    logic               jam_active;
    logic               pause_outstanding;
    logic [7:0]         ack_dly = 8'h03;
    logic [PAUSE_W-1:0] taken_time;
    logic [7:0]         taken_cnt;
    int                 bad_count = 0;
    int                 samples_checked = 0;
    int                 cyc = 0;
    int                 n;
    int                 len;
    // any, mc/bc/own select, preamble, dest valid, mc, bc, match, jam expected
    logic [9:0]         sel_case [9] = '{10'b1_100_1_0000_1, 10'b0_000_1_0000_0,
        10'b0_100_0_1100_1, 10'b0_100_0_1010_0, 10'b0_010_0_1010_1, 10'b0_001_0_1001_1,
        10'b0_011_0_1100_0, 10'b1_111_0_1111_0, 10'b0_111_0_0111_0};
    // code, 10 Mbps, jam length in 100 ns units
    int                 dur_case [6][3] = '{'{0, 0, 50}, '{3, 0, 250}, '{4, 0, 500},
        '{9, 0, 3000}, '{15, 1, 6022}, '{0, 1, 72}};

    always #5 core_clk = ~core_clk;

    rffc_flow_ctl #(.FILL_W(14), .JAM_UNIT_CYC(1)) dut (
        .core_clk(core_clk), .rst_n(rst_n), .full_duplex(full_duplex),
        .link_10m(link_10m), .rx_fill_bytes(rx_fill_bytes),
        .rx_fill_high_mark(hi_mark), .rx_fill_low_mark(lo_mark),
        .jam_duration_sel(dur_sel), .flow_ctl_any_frame(any_f),
        .flow_ctl_on_multicast(sel[2]), .flow_ctl_on_broadcast(sel[1]),
        .flow_ctl_on_own_address(sel[0]), .pause_time_value(ptv),
        .rx_preamble_ok(frm[4]), .rx_dest_valid(frm[3]), .rx_is_multicast(frm[2]),
        .rx_is_broadcast(frm[1]), .rx_addr_match(frm[0]), .pause_ack(pause_ack),
        .pause_req(pause_req), .pause_time(pause_time), .jam_active(jam_active),
        .pause_outstanding(pause_outstanding));

    rffc_mac_model mac (
        .core_clk(core_clk), .rst_n(rst_n), .ack_dly(ack_dly),
        .pause_req(pause_req), .pause_time(pause_time), .pause_ack(pause_ack),
        .taken_time(taken_time), .taken_cnt(taken_cnt));

    // ==========================================================
    // access tasks
    task automatic tick(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask : tick

    // which: 0 request up, 1 jam up, 2 request down; bounded at 30 edges
    task automatic edges_until(input int which, output int cnt);
        cnt = 0;
        do begin
            @(posedge core_clk);
            #1;
            cnt++;
        end while (!(which == 0 ? pause_req === 1'b1 : which == 1 ? jam_active === 1'b1
            : pause_req === 1'b0) && cnt < 30);
    endtask : edges_until

    task automatic set_fill(input logic [13:0] v);
        @(posedge core_clk);
        rx_fill_bytes <= v;
    endtask : set_fill

    // one-cycle frame flags, then time the jam that follows
    task automatic frame(input logic [4:0] f, output int cnt, output int l);
        @(posedge core_clk);
        frm <= f;
        @(posedge core_clk);
        frm <= 5'h00;
        #1;
        edges_until(1, cnt);
        l = 0;
        while (jam_active === 1'b1 && l < 7000) begin
            tick(1);
            l++;
        end
    endtask : frame

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : give_verdict

    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            give_verdict();
        end
    end

    // ==========================================================
    // sequence
    initial begin
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        tick(4);
        `RFFC_CHK("idle request", 1'b0, pause_req)
        `RFFC_CHK("idle jam", 1'b0, jam_active)
        tick(5);
        `RFFC_CHK("below high mark", 1'b0, pause_req)
        set_fill(14'h0080);
        edges_until(0, n);
        `RFFC_CHK("pause delay", 1, n)
        edges_until(2, n);
        `RFFC_CHK("pause time", ptv, taken_time)
        `RFFC_CHK("outstanding", 1'b1, pause_outstanding)
        tick(40);
        `RFFC_CHK("single pause", 8'h01, taken_cnt)
        ack_dly <= 8'h28;
        set_fill(14'h0040);
        tick(10);
        `RFFC_CHK("at low mark", 8'h01, taken_cnt)
        set_fill(14'h003F);
        edges_until(0, n);
        `RFFC_CHK("zero pause delay", 1, n)
        tick(60);
        `RFFC_CHK("zero pause time", 16'h0000, taken_time)
        `RFFC_CHK("zero pause count", 8'h02, taken_cnt)
        `RFFC_CHK("released", 1'b0, pause_outstanding)
        @(posedge core_clk);
        any_f <= 1'b0;
        sel <= 3'h7;
        set_fill(14'h00C8);
        frame(5'h1F, n, len);
        `RFFC_CHK("no jam full duplex", 30, n)
        `RFFC_CHK("no pause without any", 8'h02, taken_cnt)
        @(posedge core_clk);
        full_duplex <= 1'b0;
        any_f <= 1'b1;
        sel <= 3'h0;
        foreach (dur_case[i]) begin
            @(posedge core_clk);
            dur_sel <= DUR_W'(dur_case[i][0]);
            link_10m <= dur_case[i][1] != 0;
            frame(5'h10, n, len);
            `RFFC_CHK("jam start", 1, n)
            `RFFC_CHK("jam length", dur_case[i][2], len)
        end
        @(posedge core_clk);
        dur_sel <= 4'h0;
        link_10m <= 1'b0;
        foreach (sel_case[i]) begin
            @(posedge core_clk);
            any_f <= sel_case[i][9];
            sel <= sel_case[i][8:6];
            frame(sel_case[i][5:1], n, len);
            `RFFC_CHK("jam on selection", sel_case[i][0], n == 1)
        end
        @(posedge core_clk);
        any_f <= 1'b1;
        set_fill(14'h007F);
        frame(5'h10, n, len);
        `RFFC_CHK("no jam below mark", 30, n)
        `RFFC_CHK("no pause half duplex", 8'h02, taken_cnt)
        give_verdict();
    end
endmodule : rffc_flow_ctl_tb

`default_nettype wire
